//--- bench/map_mem_model.sv
// Memory system model: completes each issued access after a latency
`timescale 1ns/10ps
module map_mem_model
(
   input  wire logic       pclk,      // Clock
   input  wire logic       presetn,   // Reset, low
   input  wire logic       rsp_valid, // Access issued
   input  wire logic       rsp_err,   // Access refused
   input  wire logic [3:0] lat,       // Wait cycles before each completion
   output logic            mem_cmp    // One access completed
);
   int pend;
   int wait_cnt;

   // Refused accesses never reach memory, so they never complete
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         pend = 0;
         wait_cnt = 0;
         mem_cmp <= 1'b0;
      end
      else
      begin
         mem_cmp <= 1'b0;
         if (pend > 0 && wait_cnt >= lat)
         begin
            mem_cmp <= 1'b1;
            pend--;
            wait_cnt = 0;
         end
         else if (pend > 0)
            wait_cnt++;
         if (rsp_valid && !rsp_err)
            pend++;
      end
endmodule // map_mem_model

//--- bench/map_policy_properties.sv
// Concurrent checks on the memory attribute policy ports
`timescale 1ns/10ps
module map_policy_properties
   import map_pkg::*;
(
   input wire logic        pclk,            // Clock
   input wire logic        presetn,         // Reset, low
   input wire logic        req_valid,       // Request
   input wire logic        req_ready,       // Request taken
   input wire logic [31:0] req_addr,        // Address
   input wire logic [1:0]  req_size,        // Log2 bytes
   input wire logic        req_replay,      // Reissue
   input wire logic        bar_valid,       // Barrier request
   input wire logic        bar_ready,       // Barrier done
   input wire logic        rsp_valid,       // Result pulse
   input wire map_type_e   rsp_type,        // Memory type
   input wire logic        rsp_shared,      // Sharing flag
   input wire logic        rsp_cacheable,   // May be cached
   input wire logic        rsp_bufferable,  // May be buffered
   input wire logic        rsp_may_repeat,  // Repeat allowed
   input wire logic        rsp_may_merge,   // Merge allowed
   input wire logic        rsp_may_reorder, // Reorder allowed
   input wire logic        rsp_may_forward, // Forward allowed
   input wire logic        rsp_err          // Refused
);
   // ****************************************************
   // Sequences and properties
   // ****************************************************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence take;
      req_valid && req_ready;
   endsequence
   sequence ok_rsp;
      rsp_valid && !rsp_err;
   endsequence
   sequence so_issued;
      ok_rsp ##0 rsp_type == MAP_SO;
   endsequence

   a_rsp_follows: assert property (take |=> rsp_valid)
      else $error("no result after a taken request");
   a_rsp_cause: assert property (rsp_valid |->
      $past(req_valid && req_ready)) else $error("result without a request");
   a_attr_hold: assert property (!rsp_valid |-> $stable(rsp_type))
      else $error("attribute changed without a result");
   a_one_type: assert property (rsp_valid |-> rsp_type != 2'h3)
      else $error("undefined memory type");
   a_so_shared: assert property (so_issued |-> rsp_shared &&
      !rsp_cacheable && !rsp_bufferable)
      else $error("strongly ordered misqualified");
   a_dev_nocache: assert property (ok_rsp ##0 rsp_type == MAP_DEV |->
      !rsp_cacheable) else $error("device cacheable");
   a_io_strict: assert property (ok_rsp ##0 rsp_type != MAP_NORM
      |-> !(rsp_may_repeat || rsp_may_merge || rsp_may_reorder))
      else $error("side effect region relaxed");
   a_norm_free: assert property (ok_rsp ##0
      rsp_type == MAP_NORM |-> rsp_may_repeat && rsp_may_merge &&
      rsp_may_reorder && rsp_may_forward)
      else $error("normal region restricted");
   a_so_fence: assert property (so_issued |->
      !req_ready && !bar_ready) else $error("strongly ordered not fenced");
   a_replay_refused: assert property (take ##0 req_replay |=>
      rsp_err || rsp_type == MAP_NORM) else $error("replay issued");
   a_unaligned_io: assert property (take ##0 (req_size == 2'h2 &&
      req_addr[1:0] != 2'h0) |=> rsp_err || rsp_type == MAP_NORM)
      else $error("unaligned side effect access");
   a_bar_stall: assert property (bar_valid |-> !req_ready)
      else $error("request taken during barrier");
   a_bar_drain: assert property (bar_valid && rsp_valid |->
      !bar_ready) else $error("barrier passed pending result");
endmodule // map_policy_properties

bind map_policy map_policy_properties u_props (.*);

//--- bench/tb_top.sv
// Self-checking testbench for the memory attribute policy block
`timescale 1ns/10ps
module tb_top
   import map_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, req_addr, rv;
   logic        req_valid, req_ready, req_write, req_replay, bar_valid;
   logic        bar_ready, mem_cmp, rsp_valid, rsp_shared, rsp_cacheable;
   logic        rsp_wback, rsp_bufferable, rsp_may_repeat, rsp_may_merge;
   logic        rsp_may_reorder, rsp_may_forward, rsp_err, ev;
   logic [1:0]  req_size, r;
   logic [3:0]  lat;
   map_type_e   rsp_type;
   logic [13:0] q[$];
   logic [13:0] e, er[4], lg[4];
   int          bad_count, checks_done, cyc, t0;
   integer      seed;

   map_policy DUT (.*);
   map_mem_model u_mem (.*);

   // ****************************************************
   // Tasks
   // ****************************************************
   task automatic check(input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x)
      begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Expected {mask, err, type, shared, cacheable, wback, bufferable}
   function automatic logic [13:0] ex(input map_type_e t,
      input logic sh, c, w, x);
      logic [6:0] m;
      m = x ? 7'h40 : (t == MAP_NORM ? 7'h7E : 7'h7F);
      return {m, x, t, sh, c, w, t == MAP_DEV};
   endfunction
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d,
      input logic x);
      apb(1'b0, a, 32'h0);
      check(rv, d);
      check({31'h0, ev}, {31'h0, x});
   endtask
   // Holds the request until the edge that takes it; caller releases
   task automatic acc(input logic [31:0] a, input logic [1:0] sz,
      input logic rp, input logic [13:0] x);
      q.push_back(x);
      req_valid <= 1'b1;
      req_addr <= a;
      req_size <= sz;
      req_replay <= rp;
      req_write <= 1'($random(seed));
      do @(posedge pclk); while (req_ready !== 1'b1);
   endtask
   task automatic bar();
      req_valid <= 1'b0;
      bar_valid <= 1'b1;
      do @(posedge pclk); while (bar_ready !== 1'b1);
      bar_valid <= 1'b0;
   endtask

   // ****************************************************
   // Clock, watchdog and result monitor
   // ****************************************************
   always #5 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cyc = cyc + 1;
      if (cyc == 6000)
      begin
         bad_count++;
         $display("ERROR %0t run timed out", $time);
         conclude();
      end
   end
   always @(negedge pclk)
      if (presetn === 1'b1 && rsp_valid === 1'b1)
      begin
         check({31'h0, q.size() > 0}, 32'h1);
         e = q.pop_front();
         check({25'h0, {rsp_err, rsp_type, rsp_shared, rsp_cacheable,
            rsp_wback, rsp_bufferable} & e[13:7]},
            {25'h0, e[6:0] & e[13:7]});
      end

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial
   begin
      seed = 32'h52FA;
      {pclk, presetn, psel, penable, pwrite, req_valid, bar_valid} = 7'h00;
      {req_write, req_replay, cyc, bad_count, checks_done} = 0;
      paddr = 12'h000;
      pwdata = 32'h0;
      req_addr = 32'h0;
      req_size = 2'h2;
      lat = 4'h1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(MAP_OFF_CTRL, MAP_CTRL_RST, 1'b0);
      rd(MAP_OFF_ERRCNT, 32'h0, 1'b0);
      rd(MAP_OFF_RGN0 + MAP_SUB_ATTR, 32'h0, 1'b0);
      rd(12'hFF0, 32'h0, 1'b1);
      apb(1'b1, MAP_OFF_STAT, 32'hFFFF_FFFF);
      rd(MAP_OFF_STAT, 32'h0, 1'b0);
      acc(32'h0000_8000, 2'h2, 1'b0, ex(MAP_SO, 1, 0, 0, 0));
      $display("test reset values done");
      er = '{ex(MAP_NORM, 0, 0, 0, 0), ex(MAP_SO, 1, 0, 0, 0),
             ex(MAP_DEV, 1, 0, 0, 0), ex(MAP_NORM, 1, 1, 1, 0)};
      lg = '{ex(MAP_NORM, 0, 1, 1, 0), ex(MAP_NORM, 0, 1, 0, 0),
             ex(MAP_DEV, 0, 0, 0, 0), ex(MAP_SO, 1, 0, 0, 0)};
      for (int i = 0; i < 4; i++)
      begin
         if (i == 0)
            req_valid <= 1'b0;
         apb(1'b1, 12'(16 + 16 * i), 32'h1000 * (i + 1));
         apb(1'b1, 12'(20 + 16 * i), 32'h1000 * (i + 1) + 32'hFFF);
         apb(1'b1, 12'(24 + 16 * i), {24'h0, 8'h16 >> (i * 2)} & 32'h16);
      end
      // Region attributes: 16 normal shared wb, 05 device, 00 so, 02 normal
      apb(1'b1, 12'h028, 32'h05);
      apb(1'b1, 12'h048, 32'h02);
      rd(12'h028, 32'h05, 1'b0);
      repeat (16)
      begin
         r = 2'($random(seed));
         lat <= (($random(seed) & 1) != 0) ? 4'h8 : 4'h0;
         acc(32'h1000 * (r + 1) + (32'($random(seed)) & 32'hFFC), 2'h2,
            1'b0, er[~r]);
      end
      $display("test region decode done");
      acc(32'h2004, 2'h2, 1'b1, ex(MAP_DEV, 0, 0, 0, 1));
      acc(32'h2006, 2'h2, 1'b0, ex(MAP_DEV, 0, 0, 0, 1));
      acc(32'h3001, 2'h1, 1'b0, ex(MAP_SO, 0, 0, 0, 1));
      acc(32'h1003, 2'h2, 1'b0, er[3]);
      acc(32'h1000, 2'h3, 1'b1, er[3]);
      req_valid <= 1'b0;
      rd(MAP_OFF_ERRCNT, 32'h3, 1'b0);
      $display("test refusals done");
      lat <= 4'h8;
      acc(32'h3000, 2'h2, 1'b0, er[1]);
      t0 = cyc;
      acc(32'h1000, 2'h2, 1'b0, er[3]);
      check({31'h0, cyc - t0 > 8}, 32'h1);
      acc(32'h4000, 2'h2, 1'b0, er[0]);
      bar();
      rd(MAP_OFF_STAT, 32'h0, 1'b0);
      $display("test ordering done");
      apb(1'b1, MAP_OFF_CTRL, 32'h3);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, 12'h048, 32'(i) << MAP_ATTR_BUF);
         acc(32'h4000, 2'h2, 1'b0, lg[3 - i]);
         req_valid <= 1'b0;
      end
      apb(1'b1, MAP_OFF_CTRL, 32'h7);
      acc(32'h4000, 2'h2, 1'b0, lg[0] & 14'h3FFD);
      req_valid <= 1'b0;
      apb(1'b1, 12'h048, 32'h40);
      apb(1'b1, MAP_OFF_CTRL, 32'hB);
      acc(32'h4000, 2'h2, 1'b0, ex(MAP_NORM, 0, 0, 0, 1));
      req_valid <= 1'b0;
      rd(MAP_OFF_ERRCNT, 32'h4, 1'b0);
      apb(1'b1, MAP_OFF_CTRL, 32'h0);
      acc(32'h1000, 2'h2, 1'b0, er[1]);
      req_valid <= 1'b0;
      $display("test legacy decode done");
      repeat (20) @(posedge pclk);
      check({31'h0, q.size() == 0}, 32'h1);
      conclude();
   end
endmodule // tb_top

//--- core/map_attr_dec.sv
// Attribute decoder: raw region attribute to memory type and qualifiers
`timescale 1ns/10ps
module map_attr_dec
   import map_pkg::*;
(
   input  wire logic       legacy,       // Two-bit cacheable/bufferable mode
   input  wire map_ckind_e ckind,        // Organisation of the data cache
   input  wire logic [6:0] attr,         // Raw region attribute
   output map_type_e       mtype,        // Decoded memory type
   output logic            shared,       // Region reachable by other masters
   output map_cpol_e       cpol,         // Cache policy
   output logic            bufferable,   // Writes may sit in a write buffer
   output logic            unpred        // Encoding has no defined meaning
);

   logic c_bit;
   logic b_bit;

   always_comb
   begin
      c_bit      = attr[MAP_ATTR_CACHE];
      b_bit      = attr[MAP_ATTR_BUF];
      mtype      = MAP_SO;
      cpol       = MAP_NC;
      bufferable = 1'b0;
      unpred     = 1'b0;
      if (legacy)
      begin
         bufferable = b_bit;
         case ({c_bit, b_bit})
            2'b00: mtype = MAP_SO;
            2'b01: mtype = MAP_DEV;
            2'b11:
            begin
               mtype = MAP_NORM;
               cpol  = (ckind == MAP_CK_WT_ONLY) ? MAP_WT : MAP_WB;
            end
            2'b10:
            begin
               // Write-through-only caches define this as write-through
               if (ckind == MAP_CK_WB_ONLY)
               begin
                  unpred = 1'b1;
               end
               else
               begin
                  mtype = MAP_NORM;
                  cpol  = MAP_WT;
               end
            end
            default: mtype = MAP_SO;
         endcase
      end
      else
      begin
         case (attr[MAP_ATTR_TYPE +: 2])
            2'b00: mtype = MAP_SO;
            2'b01:
            begin
               mtype      = MAP_DEV;
               bufferable = 1'b1;
            end
            2'b10:
            begin
               mtype      = MAP_NORM;
               bufferable = 1'b1;
               case (attr[MAP_ATTR_CPOL +: 2])
                  2'b00:   cpol = MAP_NC;
                  2'b01:   cpol = MAP_WT;
                  2'b10:   cpol = MAP_WB;
                  default:
                  begin
                     cpol   = MAP_NC;
                     unpred = 1'b1;
                  end
               endcase
            end
            default: unpred = 1'b1;
         endcase
      end
      // Strongly ordered carries no own sharing bit
      shared = (mtype == MAP_SO) ? 1'b1 : attr[MAP_ATTR_SHARED];
   end

endmodule // map_attr_dec

//--- core/map_policy.sv
// Memory attribute policy: region table, attribute decode, access ordering
//
// Summary of operation
// - Each legacy region has bufferable and cacheable bits
// - Legacy C/B pair decodes per cache organisation
// - Region is exactly one of three types
// - Normal may repeat, restart, replay non-atomically
// - Normal may merge writes and prefetch reads
// - Normal may be accessed unaligned
// - Device and strongly ordered never reissued
// - Device/strongly ordered keep count, width, sequence
// - Strongly ordered accesses strictly in program order
// - Strongly ordered always treated as shared
// - Per-region sharing flag is honoured
// - Normal carries share and cache policy qualifiers
// - Normal load returns own latest store
// - Repeated loads without store match
// - Normal accesses may be reordered weakly
// - Non-shared normal needs no cache transparency
// - Ordering barrier honoured for buffered forwarding
// - Device non-cacheable, merging keeps shape
// - Strongly ordered never allocated in cache
// - Strongly ordered fenced by barrier both sides
`timescale 1ns/10ps
module map_policy
   import map_pkg::*;
#(
   parameter int NREG  = 4,    // Number of programmable regions
   parameter int CNT_W = 4     // Width of the outstanding access count
)
(
   input  wire logic        pclk,            // Core clock
   input  wire logic        presetn,         // Asynchronous reset, low
   input  wire logic        psel,            // APB select
   input  wire logic        penable,         // APB enable
   input  wire logic        pwrite,          // APB direction
   input  wire logic [11:0] paddr,           // APB byte address
   input  wire logic [31:0] pwdata,          // APB write data
   output logic [31:0]      prdata,          // APB read data
   output logic             pready,          // APB ready
   output logic             pslverr,         // APB error
   input  wire logic        req_valid,       // Load/store request
   output logic             req_ready,       // Request taken
   input  wire logic [31:0] req_addr,        // Access address
   input  wire logic        req_write,       // Store when high
   input  wire logic [1:0]  req_size,        // Log2 of access bytes
   input  wire logic        req_replay,      // Reissue of earlier access
   input  wire logic        bar_valid,       // ordering_barrier request
   output logic             bar_ready,       // Barrier complete
   input  wire logic        mem_cmp,         // One access completed
   output logic             rsp_valid,       // Lookup result pulse
   output map_type_e        rsp_type,        // Memory type
   output logic             rsp_shared,      // Sharing flag
   output logic             rsp_cacheable,   // May be cached
   output logic             rsp_wback,       // Write-back policy
   output logic             rsp_bufferable,  // Writes may be buffered
   output logic             rsp_may_repeat,  // Repeat/restart/replay ok
   output logic             rsp_may_merge,   // Merge/prefetch permitted
   output logic             rsp_may_reorder, // Weak ordering permitted
   output logic             rsp_may_forward, // Buffer forwarding permitted
   output logic             rsp_err          // Access refused
);

   // ****************************************************
   // Parameter checks
   // ****************************************************
   // Refused at elaboration: region index and status fields are fixed
   if (NREG < 1 || NREG > 15)
      $error("map_policy: NREG must lie in 1..15");
   if (CNT_W < 1 || CNT_W > 16)
      $error("map_policy: CNT_W must lie in 1..16");

   // ****************************************************
   // State
   // ****************************************************
   typedef struct packed {
      logic [31:0]                ctrl;
      logic [NREG-1:0][31:0]      base;
      logic [NREG-1:0][31:0]      limit;
      logic [NREG-1:0][6:0]       attr;
      logic [31:0]                prdata;
      logic                       pslverr;
      map_state_e                 st;
      logic [CNT_W-1:0]           outst;
      logic [15:0]                errcnt;
      logic                       rsp_valid;
      map_type_e                  rsp_type;
      logic                       rsp_shared;
      logic                       rsp_cacheable;
      logic                       rsp_wback;
      logic                       rsp_bufferable;
      logic                       rsp_may_repeat;
      logic                       rsp_may_merge;
      logic                       rsp_may_reorder;
      logic                       rsp_may_forward;
      logic                       rsp_err;
   } map_state_s;

   map_state_s r;
   map_state_s next_r;

   // ****************************************************
   // Region lookup
   // ****************************************************
   // Lowest numbered hit wins so overlapping regions stay defined
   function automatic logic [6:0] map_lookup(input map_state_s s,
                                             input logic [31:0] a);
      logic [6:0] res;
      res = MAP_ATTR_MISS;
      for (int i = NREG - 1; i >= 0; i--)
      begin
         if (a >= s.base[i] && a <= s.limit[i])
            res = s.attr[i];
      end
      return res;
   endfunction

   // Region selected by an APB address, NREG when none
   function automatic logic [3:0] map_rgn_sel(input logic [11:0] a);
      logic [11:0] rel;
      logic [3:0]  idx;
      rel = a - MAP_OFF_RGN0;
      idx = rel[7:4];
      if (a < MAP_OFF_RGN0 || rel[11:8] != 4'h0 || idx >= NREG[3:0])
         idx = NREG[3:0];
      return idx;
   endfunction

   logic [6:0] look_attr;
   map_type_e  dec_type;
   logic       dec_shared;
   map_cpol_e  dec_cpol;
   logic       dec_buf;
   logic       dec_unpred;

   assign look_attr = r.ctrl[MAP_CTRL_EN] ? map_lookup(r, req_addr)
                                          : MAP_ATTR_MISS;

   map_attr_dec u_dec (
      .legacy     (r.ctrl[MAP_CTRL_LEGACY]),
      .ckind      (map_ckind_e'(r.ctrl[MAP_CTRL_CK_LSB +: 2])),
      .attr       (look_attr),
      .mtype      (dec_type),
      .shared     (dec_shared),
      .cpol       (dec_cpol),
      .bufferable (dec_buf),
      .unpred     (dec_unpred)
   );

   // ****************************************************
   // Handshakes
   // ****************************************************
   logic mem_idle;
   logic cnt_full;
   logic unaligned;
   logic take_req;
   logic take_bar;

   assign mem_idle  = (r.outst == '0) && !r.rsp_valid;
   assign cnt_full  = (r.outst == {CNT_W{1'b1}});
   assign unaligned = (req_size == 2'h1 && req_addr[0]) ||
                      (req_size == 2'h2 && req_addr[1:0] != 2'h0) ||
                      (req_size == 2'h3 && req_addr[2:0] != 3'h0);

   // Strongly ordered waits until all earlier accesses drained
   assign req_ready = (r.st == MAP_ST_IDLE) && !bar_valid && !cnt_full &&
                      (dec_type != MAP_SO || mem_idle);
   // Barrier completes only once nothing is buffered or in flight
   assign bar_ready = (r.st == MAP_ST_IDLE) && mem_idle;
   assign take_req  = req_valid && req_ready;
   assign take_bar  = bar_valid && bar_ready;

   assign pready          = 1'b1;
   assign prdata          = r.prdata;
   assign pslverr         = r.pslverr;
   assign rsp_valid       = r.rsp_valid;
   assign rsp_type        = r.rsp_type;
   assign rsp_shared      = r.rsp_shared;
   assign rsp_cacheable   = r.rsp_cacheable;
   assign rsp_wback       = r.rsp_wback;
   assign rsp_bufferable  = r.rsp_bufferable;
   assign rsp_may_repeat  = r.rsp_may_repeat;
   assign rsp_may_merge   = r.rsp_may_merge;
   assign rsp_may_reorder = r.rsp_may_reorder;
   assign rsp_may_forward = r.rsp_may_forward;
   assign rsp_err         = r.rsp_err;

   // ****************************************************
   // Next state
   // ****************************************************
   logic [3:0]  sel;
   logic [3:0]  sub;
   logic        is_norm;
   logic        refuse;
   logic        issued;

   always_comb
   begin
      next_r = r;
      sel    = map_rgn_sel(paddr);
      sub    = paddr[3:0];
      is_norm = (dec_type == MAP_NORM);

      // APB: read data set up in the setup cycle, zero wait states
      if (psel && !penable)
      begin
         next_r.pslverr = 1'b0;
         next_r.prdata  = 32'h0000_0000;
         if (paddr == MAP_OFF_CTRL)
            next_r.prdata = r.ctrl;
         else if (paddr == MAP_OFF_STAT)
            next_r.prdata = {{(30 - CNT_W){1'b0}}, r.outst, r.st};
         else if (paddr == MAP_OFF_ERRCNT)
            next_r.prdata = {16'h0000, r.errcnt};
         else if (sel != NREG[3:0] && sub == MAP_SUB_BASE)
            next_r.prdata = r.base[sel];
         else if (sel != NREG[3:0] && sub == MAP_SUB_LIMIT)
            next_r.prdata = r.limit[sel];
         else if (sel != NREG[3:0] && sub == MAP_SUB_ATTR)
            next_r.prdata = {25'h0, r.attr[sel]};
         else
            next_r.pslverr = 1'b1;
      end
      if (psel && penable && pwrite && !r.pslverr)
      begin
         if (paddr == MAP_OFF_CTRL)
            next_r.ctrl = {28'h0000000, pwdata[3:0]};
         else if (sel != NREG[3:0] && sub == MAP_SUB_BASE)
            next_r.base[sel] = pwdata;
         else if (sel != NREG[3:0] && sub == MAP_SUB_LIMIT)
            next_r.limit[sel] = pwdata;
         else if (sel != NREG[3:0] && sub == MAP_SUB_ATTR)
            next_r.attr[sel] = pwdata[MAP_ATTR_W-1:0];
      end

      // Device and strongly ordered never take a reissue or an
      // unaligned access; refused accesses never reach memory
      refuse = dec_unpred ||
               (!is_norm && (req_replay || unaligned));
      issued = take_req && !refuse;

      // Result appears with its attributes in one cycle
      next_r.rsp_valid       = take_req;
      if (take_req)
      begin
         next_r.rsp_type        = dec_type;
         next_r.rsp_shared      = dec_shared;
         // Device and strongly ordered are never cached or allocated
         next_r.rsp_cacheable   = is_norm && dec_cpol != MAP_NC;
         next_r.rsp_wback       = is_norm && dec_cpol == MAP_WB;
         next_r.rsp_bufferable  = dec_buf && dec_type != MAP_SO;
         next_r.rsp_may_repeat  = is_norm;
         next_r.rsp_may_merge   = is_norm;
         next_r.rsp_may_reorder = is_norm;
         // Own stores forwarded so loads see the latest value
         next_r.rsp_may_forward = is_norm;
         next_r.rsp_err         = refuse;
      end
      if (take_req && refuse && r.errcnt != 16'hFFFF)
         next_r.errcnt = r.errcnt + 16'h0001;

      // Outstanding count; completion reported by memory side
      if (issued && !mem_cmp)
         next_r.outst = r.outst + {{(CNT_W-1){1'b0}}, 1'b1};
      else if (!issued && mem_cmp && r.outst != '0)
         next_r.outst = r.outst - {{(CNT_W-1){1'b0}}, 1'b1};

      // Completion seen by the issuer only through polling the
      // peripheral; this block just holds later accesses back
      case (r.st)
         MAP_ST_IDLE:
         begin
            if (issued && dec_type == MAP_SO)
               next_r.st = MAP_ST_DRAIN;
         end
         MAP_ST_DRAIN:
         begin
            if (mem_idle)
               next_r.st = MAP_ST_IDLE;
         end
         default: next_r.st = MAP_ST_IDLE;
      endcase
      if (take_bar)
         next_r.st = MAP_ST_IDLE;
   end

   // ****************************************************
   // Registers
   // ****************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r                 <= '0;
         r.ctrl            <= MAP_CTRL_RST;
         r.base            <= {NREG{MAP_BASE_RST}};
         r.limit           <= {NREG{MAP_LIMIT_RST}};
         r.attr            <= {NREG{MAP_ATTR_RST}};
         r.st              <= MAP_ST_IDLE;
         r.rsp_type        <= MAP_SO;
      end
      else
      begin
         r <= next_r;
      end
   end

endmodule // map_policy

//--- inc/map_pkg.sv
// Package of constants and types for the memory attribute policy block
package map_pkg;

   // ****************************************************
   // Register map
   // ****************************************************
   localparam logic [11:0] MAP_OFF_CTRL    = 12'h000;
   localparam logic [11:0] MAP_OFF_STAT    = 12'h004;
   localparam logic [11:0] MAP_OFF_ERRCNT  = 12'h008;
   localparam logic [11:0] MAP_OFF_RGN0    = 12'h010;
   localparam logic [11:0] MAP_RGN_STRIDE  = 12'h010;
   localparam logic [3:0]  MAP_SUB_BASE    = 4'h0;
   localparam logic [3:0]  MAP_SUB_LIMIT   = 4'h4;
   localparam logic [3:0]  MAP_SUB_ATTR    = 4'h8;

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int MAP_CTRL_EN      = 0;
   localparam int MAP_CTRL_LEGACY  = 1;
   localparam int MAP_CTRL_CK_LSB  = 2;
   localparam int MAP_ATTR_TYPE    = 0;
   localparam int MAP_ATTR_SHARED  = 2;
   localparam int MAP_ATTR_CPOL    = 3;
   localparam int MAP_ATTR_BUF     = 5;
   localparam int MAP_ATTR_CACHE   = 6;
   localparam int MAP_ATTR_W       = 7;

   // ****************************************************
   // Reset values
   // ****************************************************
   localparam logic [31:0] MAP_CTRL_RST   = 32'h0000_0001;
   localparam logic [31:0] MAP_BASE_RST   = 32'h0000_0000;
   localparam logic [31:0] MAP_LIMIT_RST  = 32'h0000_0000;
   localparam logic [6:0]  MAP_ATTR_RST   = 7'h00;
   // Addresses outside every region fall back to the safest type
   localparam logic [6:0]  MAP_ATTR_MISS  = 7'h00;

   // ****************************************************
   // Enumerations
   // ****************************************************
   typedef enum logic [1:0] {
      MAP_SO   = 2'b00,
      MAP_DEV  = 2'b01,
      MAP_NORM = 2'b10
   } map_type_e;

   typedef enum logic [1:0] {
      MAP_NC = 2'b00,
      MAP_WT = 2'b01,
      MAP_WB = 2'b10
   } map_cpol_e;

   typedef enum logic [1:0] {
      MAP_CK_COMBINED = 2'b00,
      MAP_CK_WT_ONLY  = 2'b01,
      MAP_CK_WB_ONLY  = 2'b10
   } map_ckind_e;

   typedef enum logic [1:0] {
      MAP_ST_IDLE  = 2'b00,
      MAP_ST_DRAIN = 2'b01
   } map_state_e;

endpackage
